/* inc/bcss_pkg.sv */
// Shared constants and types for the board clock select and strap block
package bcss_pkg;

    // Core clock and reference rates, in kHz
    localparam int unsigned CORE_CLK_KHZ    = 200000;
    localparam int unsigned REF_CLK_KHZ     = 14318;

    // Strap sampling window, counted in reference clock rising edges
    localparam int unsigned STRAP_WINDOW_US = 2000;
    localparam int unsigned STRAP_REF_EDGES = (STRAP_WINDOW_US * REF_CLK_KHZ) / 1000;
    localparam int unsigned STRAP_CNT_W     = 16;

    // Host and PCI target rates, in kHz
    localparam int unsigned HOST_FAST_KHZ   = 100000;
    localparam int unsigned HOST_SLOW_KHZ   = 66800;
    localparam int unsigned PCI_FAST_KHZ    = 33300;

    // Core cycles per output period, rounded to the nearest whole cycle
    localparam logic [2:0]  HOST_DIV_FAST   = 3'((CORE_CLK_KHZ + HOST_FAST_KHZ / 2) / HOST_FAST_KHZ);
    localparam logic [2:0]  HOST_DIV_SLOW   = 3'((CORE_CLK_KHZ + HOST_SLOW_KHZ / 2) / HOST_SLOW_KHZ);
    localparam logic [2:0]  PCI_DIV         = 3'((CORE_CLK_KHZ + PCI_FAST_KHZ / 2) / PCI_FAST_KHZ);

    // Phase accumulator for the 48 MHz USB clock
    localparam int unsigned NCO_W           = 32;
    localparam int unsigned USB_CLK_KHZ     = 48000;
    localparam logic [31:0] USB_NCO_INC     =
        32'((64'(USB_CLK_KHZ) << 32) / 64'(CORE_CLK_KHZ));

    // Values after reset
    localparam logic        STRAP_RESET     = 1'b0;
    localparam logic [2:0]  DIV_CNT_RESET   = 3'h0;

    // Strap sequencer states
    typedef enum logic [0:0] {
        BCSS_ST_SAMPLE = 1'b0,
        BCSS_ST_RUN    = 1'b1
    } bcss_state_t;

    // All clock outputs that leave the block together
    typedef struct packed {
        logic [1:0] host_clock_outs;
        logic [5:0] gated_pci_clock_outs;
        logic       free_pci_clock_out;
        logic       interrupt_ctrl_clock_out;
        logic       usb_clock_out;
        logic       switchable_aux_clock_out;
    } bcss_clk_bundle_t;

endpackage : bcss_pkg

/* verilog/bcss_top.sv */
// Board clock select, power-up strap latch and clock output logic
`timescale 1ns/1ps
`default_nettype none

module bcss_top #(
    parameter int unsigned STRAP_REF_EDGES = bcss_pkg::STRAP_REF_EDGES
) (
    // Clock and power-on reset
    input  wire logic                       core_clk_i,
    input  wire logic                       rst_n_i,
    // Reference and static selects
    input  wire logic                       reference_input_i,
    input  wire logic                       host_rate_select_i,
    input  wire logic [5:0]                 pci_gate_enable_i,
    // Dual-purpose strap / reference pin
    input  wire logic                       strap_or_reference_pin_i,
    output logic                            strap_or_reference_pin_o,
    output logic                            strap_or_reference_pin_oe_n_o,
    // Clock outputs and strap status
    output bcss_pkg::bcss_clk_bundle_t      clocks_o,
    output logic                            aux_rate_strap_o,
    output logic                            strap_latched_o
);

    // Refuse window lengths the counter cannot hold
    if (STRAP_REF_EDGES < 1 || STRAP_REF_EDGES >= (1 << bcss_pkg::STRAP_CNT_W)) begin : g_chk
        $error("bcss_top: STRAP_REF_EDGES out of range");
    end

    // Dividers of zero would break the modulo; one counter needs whole host periods
    if (bcss_pkg::HOST_DIV_FAST == 3'h0 || bcss_pkg::HOST_DIV_SLOW == 3'h0 ||
        bcss_pkg::PCI_DIV < 3'h2) begin : g_chk_div
        $error("bcss_top: divider constants out of range");
    end
    if ((bcss_pkg::PCI_DIV % bcss_pkg::HOST_DIV_FAST) != 3'h0 ||
        (bcss_pkg::PCI_DIV % bcss_pkg::HOST_DIV_SLOW) != 3'h0) begin : g_chk_sync
        $error("bcss_top: PCI period not a whole number of host periods");
    end

    localparam logic [bcss_pkg::STRAP_CNT_W-1:0] STRAP_TERM =
        bcss_pkg::STRAP_CNT_W'(STRAP_REF_EDGES - 1);

    // Host phase is high on the first core cycle of each host period
    function automatic logic host_phase_high(input logic [2:0] cnt, input logic fast);
        logic [2:0] div;
        div = fast ? bcss_pkg::HOST_DIV_FAST : bcss_pkg::HOST_DIV_SLOW;
        return (cnt % div) == 3'h0;
    endfunction : host_phase_high

    // ------------------------------------------------------------------
    // Strap sequencer state
    // ------------------------------------------------------------------
    bcss_pkg::bcss_state_t                  state_q;
    bcss_pkg::bcss_state_t                  state_d;
    logic [bcss_pkg::STRAP_CNT_W-1:0]       win_cnt_q;
    logic [bcss_pkg::STRAP_CNT_W-1:0]       win_cnt_d;
    logic                                   strap_q;
    logic                                   strap_d;
    logic                                   ref_prev_q;
    logic                                   ref_edge;

    // Window runs on reference rising edges so it tracks the crystal
    // A reference already high at release counts once; negligible in a long window
    always_comb begin
        state_d   = state_q;
        win_cnt_d = win_cnt_q;
        strap_d   = strap_q;
        ref_edge  = reference_input_i & ~ref_prev_q;
        unique case (state_q)
            bcss_pkg::BCSS_ST_SAMPLE: begin
                if (ref_edge) begin
                    if (win_cnt_q == STRAP_TERM) begin
                        strap_d = strap_or_reference_pin_i;
                        state_d = bcss_pkg::BCSS_ST_RUN;
                    end else begin
                        win_cnt_d = win_cnt_q + 1'b1;
                    end
                end
            end
            bcss_pkg::BCSS_ST_RUN: begin
                // No way back: only power-on reset restarts sampling
                state_d = bcss_pkg::BCSS_ST_RUN;
            end
        endcase
    end

    // Register strap sequencer; reset stands for power-on
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q    <= bcss_pkg::BCSS_ST_SAMPLE;
            win_cnt_q  <= '0;
            strap_q    <= bcss_pkg::STRAP_RESET;
            ref_prev_q <= 1'b0;
        end else begin
            state_q    <= state_d;
            win_cnt_q  <= win_cnt_d;
            strap_q    <= strap_d;
            ref_prev_q <= reference_input_i;
        end
    end

    // ------------------------------------------------------------------
    // Host / PCI divider: one counter keeps both families in phase
    // ------------------------------------------------------------------
    logic [2:0]                             div_cnt_q;
    logic [2:0]                             div_cnt_d;
    logic                                   host_lvl;
    logic                                   pci_lvl;

    // PCI period is six core cycles at either select setting
    always_comb begin
        if (div_cnt_q == bcss_pkg::PCI_DIV - 3'h1) begin
            div_cnt_d = bcss_pkg::DIV_CNT_RESET;
        end else begin
            div_cnt_d = div_cnt_q + 3'h1;
        end
        host_lvl = host_phase_high(div_cnt_q, host_rate_select_i);
        pci_lvl  = div_cnt_q < (bcss_pkg::PCI_DIV >> 1);
    end

    // Register divider count
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_cnt_q <= bcss_pkg::DIV_CNT_RESET;
        end else begin
            div_cnt_q <= div_cnt_d;
        end
    end

    // ------------------------------------------------------------------
    // 48 MHz accumulator and its 24 MHz half-rate copy
    // ------------------------------------------------------------------
    logic [bcss_pkg::NCO_W-1:0]             nco_q;
    logic [bcss_pkg::NCO_W-1:0]             nco_d;
    logic                                   usb_prev_q;
    logic                                   half_q;
    logic                                   half_d;
    logic                                   usb_lvl;

    // Phase accumulator MSB gives 48 MHz with at most one core cycle jitter
    always_comb begin
        nco_d   = nco_q + bcss_pkg::USB_NCO_INC;
        usb_lvl = nco_q[bcss_pkg::NCO_W-1];
        half_d  = (usb_lvl & ~usb_prev_q) ? ~half_q : half_q;
    end

    // Register accumulator and halver
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            nco_q      <= '0;
            usb_prev_q <= 1'b0;
            half_q     <= 1'b0;
        end else begin
            nco_q      <= nco_d;
            usb_prev_q <= usb_lvl;
            half_q     <= half_d;
        end
    end

    // ------------------------------------------------------------------
    // Output stage: everything leaves from flip-flops
    // ------------------------------------------------------------------
    bcss_pkg::bcss_clk_bundle_t             clk_d;
    bcss_pkg::bcss_clk_bundle_t             clk_q;
    logic                                   pin_o_d;
    logic                                   pin_o_q;
    logic                                   pin_oe_n_d;
    logic                                   pin_oe_n_q;
    logic                                   running;

    // Compose clock bundle and pin driver
    always_comb begin
        running                        = (state_q == bcss_pkg::BCSS_ST_RUN);
        clk_d.host_clock_outs          = {2{host_lvl}};
        clk_d.gated_pci_clock_outs     = {6{pci_lvl}} & pci_gate_enable_i;
        clk_d.free_pci_clock_out       = pci_lvl;
        clk_d.interrupt_ctrl_clock_out = reference_input_i;
        clk_d.usb_clock_out            = usb_lvl;
        // Strap low picks 48 MHz, high picks the halved copy
        clk_d.switchable_aux_clock_out = strap_q ? half_q : usb_lvl;
        // Driver stays off during the window so the strap resistor wins
        pin_oe_n_d = ~running;
        pin_o_d    = running & reference_input_i;
    end

    // Register outputs
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            clk_q      <= '0;
            pin_o_q    <= 1'b0;
            pin_oe_n_q <= 1'b1;
        end else begin
            clk_q      <= clk_d;
            pin_o_q    <= pin_o_d;
            pin_oe_n_q <= pin_oe_n_d;
        end
    end

    // Drive ports
    assign clocks_o                      = clk_q;
    assign strap_or_reference_pin_o      = pin_o_q;
    assign strap_or_reference_pin_oe_n_o = pin_oe_n_q;
    assign aux_rate_strap_o              = strap_q;
    assign strap_latched_o               = (state_q == bcss_pkg::BCSS_ST_RUN);

endmodule : bcss_top

`default_nettype wire

/* tb/bcss_pin_model.sv */
// Board side: reference oscillator and strap resistor on the shared pin
`timescale 1ns/1ps
`default_nettype none
module bcss_pin_model #(parameter int HALF = 7) (
    // Clock
    input  wire logic core_clk_i,
    // Strap level and device pin driver
    input  wire logic strap_level_i,
    input  wire logic pin_drive_i,
    input  wire logic pin_oe_n_i,
    // Reference and resolved pin level
    output logic      reference_o,
    output logic      pin_o
);
    int ph = 0;
    // Reference moves off the sampling edge, near 14.3 MHz
    initial reference_o = 1'b0;
    always @(negedge core_clk_i) begin
        ph = (ph + 1) % HALF;
        if (ph == 0) reference_o <= ~reference_o;
    end
    // Resistor sets the pin only while the driver is off
    assign pin_o = pin_oe_n_i ? strap_level_i : pin_drive_i;
endmodule : bcss_pin_model
`default_nettype wire

/* tb/bcss_top_props.sv */
// Concurrent checks on the strap latch and clock outputs
`timescale 1ns/1ps
`default_nettype none
module bcss_top_props #(parameter int unsigned STRAP_REF_EDGES = 4) (
    input wire logic                       core_clk_i,
    input wire logic                       rst_n_i,
    input wire logic                       reference_input_i,
    input wire logic                       host_rate_select_i,
    input wire logic [5:0]                 pci_gate_enable_i,
    input wire logic                       strap_or_reference_pin_i,
    input wire logic                       strap_or_reference_pin_o,
    input wire logic                       strap_or_reference_pin_oe_n_o,
    input wire bcss_pkg::bcss_clk_bundle_t clocks_o,
    input wire logic                       aux_rate_strap_o,
    input wire logic                       strap_latched_o
);
    wire h0  = clocks_o.host_clock_outs[0];
    wire sel = host_rate_select_i;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    latch_hold_a: assert property (strap_latched_o |=> strap_latched_o && $stable(aux_rate_strap_o))
        else $error("strap latch changed");
    pin_hiz_a: assert property (!strap_latched_o |=> strap_or_reference_pin_oe_n_o)
        else $error("pin driven in window");
    ref_copy_a: assert property (strap_latched_o |=> !strap_or_reference_pin_oe_n_o && strap_or_reference_pin_o == $past(reference_input_i))
        else $error("reference copy wrong");
    irq_clk_a: assert property ($past(rst_n_i) |-> clocks_o.interrupt_ctrl_clock_out == $past(reference_input_i))
        else $error("interrupt clock wrong");
    host_pair_a: assert property (h0 == clocks_o.host_clock_outs[1])
        else $error("host clocks differ");
    host_fast_a: assert property (sel && $past(sel) && $past(sel, 2) && $fell(h0) |=> h0)
        else $error("fast host period");
    // Select must stay low through the cycle that sets the next high phase
    host_slow_a: assert property (!sel && !$past(sel) && !$past(sel, 2) && !$past(sel, 3)
        && $past(h0, 2) && !$past(h0) |-> !h0 ##1 h0)
        else $error("slow host period");
    pci_shape_a: assert property ($rose(clocks_o.free_pci_clock_out) |-> h0 ##1 clocks_o.free_pci_clock_out[*2] ##1 !clocks_o.free_pci_clock_out[*3])
        else $error("pci period");
    usb_period_a: assert property ($rose(clocks_o.usb_clock_out) |-> ##[4:5] $rose(clocks_o.usb_clock_out))
        else $error("usb period");
    aux_half_a: assert property ($past(strap_latched_o, 3) && aux_rate_strap_o && $rose(clocks_o.switchable_aux_clock_out) |-> ##[8:9] $rose(clocks_o.switchable_aux_clock_out))
        else $error("aux half rate");
endmodule : bcss_top_props
bind bcss_top bcss_top_props #(.STRAP_REF_EDGES(STRAP_REF_EDGES)) u_props (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .reference_input_i(reference_input_i),
    .host_rate_select_i(host_rate_select_i), .pci_gate_enable_i(pci_gate_enable_i),
    .strap_or_reference_pin_i(strap_or_reference_pin_i),
    .strap_or_reference_pin_o(strap_or_reference_pin_o),
    .strap_or_reference_pin_oe_n_o(strap_or_reference_pin_oe_n_o), .clocks_o(clocks_o),
    .aux_rate_strap_o(aux_rate_strap_o), .strap_latched_o(strap_latched_o));
`default_nettype wire

/* tb/bcss_top_bench.sv */
// Self-checking bench for the strap latch and clock output block
`timescale 1ns/1ps
`default_nettype none
module bcss_top_bench;
    localparam int SPAN = 600;
    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic host_rate_select_i = 1'b0;
    logic [5:0] pci_gate_enable_i = 6'h0;
    logic strap_level = 1'b0;
    logic strap_q, ref_prev, ref_i, pin_i, pin_drv, pin_oe_n, strap_o, latched;
    logic [31:0] lfsr = 32'h298d;
    bcss_pkg::bcss_clk_bundle_t clocks_o, clk_prev;
    int fail_count = 0;
    int compares = 0;
    int ref_rises = 0;
    int cnt [12];
    int exp_c, n;
    bcss_top #(.STRAP_REF_EDGES(4)) dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .reference_input_i(ref_i), .host_rate_select_i(host_rate_select_i),
        .pci_gate_enable_i(pci_gate_enable_i), .strap_or_reference_pin_i(pin_i),
        .strap_or_reference_pin_o(pin_drv), .strap_or_reference_pin_oe_n_o(pin_oe_n),
        .clocks_o(clocks_o), .aux_rate_strap_o(strap_o), .strap_latched_o(latched));
    bcss_pin_model board (.core_clk_i(core_clk_i), .strap_level_i(strap_level),
        .pin_drive_i(pin_drv), .pin_oe_n_i(pin_oe_n), .reference_o(ref_i), .pin_o(pin_i));
    initial begin
        forever #2.5 core_clk_i = ~core_clk_i;
    end
    // Edge counters sampled mid-cycle, where outputs are settled
    always @(negedge core_clk_i) begin
        for (int b = 0; b < 12; b++) if (clocks_o[b] === 1'b1 && clk_prev[b] === 1'b0) cnt[b]++;
        clk_prev <= clocks_o;
        ref_prev <= ref_i;
        if (!rst_n_i) ref_rises <= 0;
        else if (ref_i && !ref_prev) ref_rises <= ref_rises + 1;
    end
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr_next
    task automatic chk_bit(input logic got, input logic exp, input string what);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask : chk_bit
    task automatic chk_cnt(input int got, input int exp, input string what);
        compares++;
        if (got < exp - 1 || got > exp + 1) begin
            fail_count++;
            $display("mismatch at %0t: %s got %0d want %0d", $time, what, got, exp);
        end
    endtask : chk_cnt
    task automatic complete_run;
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : complete_run
    // Run is about 5100 cycles; a hang is cut well past that
    initial begin
        #100000;
        fail_count++;
        $display("mismatch at %0t: timeout", $time);
        complete_run;
    end
    initial begin
        for (int it = 0; it < 4; it++) begin
            @(negedge core_clk_i);
            rst_n_i = 1'b0;
            strap_level = it[0];
            strap_q = it[0];
            repeat (10) @(negedge core_clk_i);
            rst_n_i = 1'b1;
            #1 chk_bit(pin_oe_n, 1'b1, "driver on in window");
            n = 0;
            while (latched !== 1'b1 && n < 400) begin
                @(negedge core_clk_i);
                n++;
            end
            #1 chk_cnt(ref_rises, 4, "latch edge count");
            chk_bit(strap_o, strap_q, "strap value");
            // Board strap flips after the latch; it must be ignored
            strap_level = ~strap_level;
            for (int s = 0; s < 2; s++) begin
                lfsr = lfsr_next(lfsr);
                host_rate_select_i = it[1] ^ s[0];
                pci_gate_enable_i = lfsr[5:0];
                repeat (8) @(negedge core_clk_i);
                #1 for (int b = 0; b < 12; b++) cnt[b] = 0;
                repeat (SPAN) @(negedge core_clk_i);
                #1 for (int b = 0; b < 12; b++) begin
                    case (b)
                        11, 10:  exp_c = host_rate_select_i ? bcss_pkg::HOST_FAST_KHZ
                                                            : bcss_pkg::HOST_SLOW_KHZ;
                        3:       exp_c = host_rate_select_i ? bcss_pkg::PCI_FAST_KHZ
                                                            : bcss_pkg::HOST_SLOW_KHZ / 2;
                        2:       exp_c = bcss_pkg::REF_CLK_KHZ;
                        1:       exp_c = bcss_pkg::USB_CLK_KHZ;
                        0:       exp_c = strap_q ? bcss_pkg::USB_CLK_KHZ / 2 : bcss_pkg::USB_CLK_KHZ;
                        default: exp_c = pci_gate_enable_i[b - 4] ? bcss_pkg::PCI_FAST_KHZ : 0;
                    endcase
                    chk_cnt(cnt[b], SPAN * exp_c / 200000, "output edge count");
                end
            end
            chk_bit(strap_o, strap_q, "strap held");
            chk_bit(pin_oe_n, 1'b0, "driver off after window");
            $display("test %0d done", it);
        end
        complete_run;
    end
endmodule : bcss_top_bench
`default_nettype wire
